/* File: hdl/fps_pkg.sv */
// Purpose: Constants and types for Function power state tracking
// Assumes: Standard power state field encodings
// Notes: Shared by the top module and the per-Function tracker
package fps_pkg;
	localparam int NUM_FN = 4;
	localparam int FN_W = 2;
	localparam logic [1:0] PS_D0_ENC = 2'h0;
	localparam logic [1:0] PS_D3_ENC = 2'h3;
	localparam logic CTX_KEPT_RST = 1'h1;
	localparam logic [1:0] TLP_CFG0 = 2'h0;
	localparam logic [1:0] TLP_MSG = 2'h1;
	localparam logic [1:0] TLP_CPL = 2'h2;
	localparam logic [1:0] TLP_REQ = 2'h3;
	localparam logic [1:0] DISP_ACCEPT = 2'h0;
	localparam logic [1:0] DISP_UR = 2'h1;
	localparam logic [1:0] DISP_UC = 2'h2;
	localparam logic [1:0] DISP_FWD = 2'h3;
	typedef enum logic [1:0] {
		FPS_D0U = 2'b00,
		FPS_D0A = 2'b01,
		FPS_D3H = 2'b10
	} fps_state_t;
endpackage : fps_pkg

/* File: hdl/fps_fn_state.sv */
// Purpose: Power state tracker for one bridge Function
// Assumes: Write strobe is a single-cycle pulse
// Notes: D3cold is loss of power, so it has no state here
`timescale 1ns/1ps
`default_nettype none
module fps_fn_state
	import fps_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Software controls
	input wire logic i_ps_wr,
	input wire logic [1:0] i_ps_wdata,
	input wire logic i_configured,
	// State
	output fps_state_t o_state
);
	fps_state_t state_ff;
	fps_state_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			FPS_D0U: begin
				if (i_configured) begin
					nxt_state = FPS_D0A;
				end
			end
			FPS_D0A: begin
				if (i_ps_wr && i_ps_wdata == PS_D3_ENC) begin
					nxt_state = FPS_D3H;
				end
			end
			FPS_D3H: begin
				// Only the state moves; no context is cleared
				if (i_ps_wr && i_ps_wdata == PS_D0_ENC) begin
					nxt_state = FPS_D0U;
				end
			end
			default: begin
				nxt_state = FPS_D0U;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_ff <= FPS_D0U;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign o_state = state_ff;

	AST_D3_EXIT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(state_ff == FPS_D3H && i_ps_wr && i_ps_wdata == PS_D0_ENC)
		|=> state_ff == FPS_D0U)
		else $error("D3hot did not return to D0 uninitialized");
	AST_D3_ENTRY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(state_ff == FPS_D0A && i_ps_wr && i_ps_wdata == PS_D3_ENC)
		|=> state_ff == FPS_D3H)
		else $error("D0 active did not enter D3hot");
	AST_NO_D1D2: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_ff != 2'b11)
		else $error("Unsupported power state reached");
	AST_ODD_CODE: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_ps_wr && state_ff != FPS_D0U && i_ps_wdata != PS_D0_ENC
		&& i_ps_wdata != PS_D3_ENC) |=> $stable(state_ff))
		else $error("Unused power state code changed the state");
endmodule : fps_fn_state
`default_nettype wire

/* File: hdl/fps_power_ctrl.sv */
// Functional notes
// - Only D0 substates, D3hot, D3cold supported
// - D3hot to D0 resets nothing
// - Context-kept flag resets to preserved
// - Power state write affects one Function
// - Switch sleeps after upstream D3hot and ack
// - D0 entry brings the link to L0
// - D3hot entry moves the link to L1
// - Upstream port enters L1 when all D3hot
// - Downstream accepts L1 for partner D3hot
// - Downstream may reject ASPM L1 requests
// - D3hot write from D0 active enters D3hot
// - D0 write from D3hot gives D0 uninitialized
// - D3hot completes type 0 configuration requests
// - D3hot accepts messages targeting the bridge
// - Other primary requests in D3hot are UR
// - TLP-caused errors reported as in D0
// - Error send wakes link to L0 first (code sends at once, wake in parallel)
// - Non-TLP errors dropped in D3hot
// - Completions to the bridge are unexpected
// - Passing completions forwarded as in D0
// - Forwarded completion wakes link to L0
// - Secondary requests in D3hot are UR
//
// Purpose: Per-Function power state and D3hot TLP policy for a switch
// Assumes: Function 0 is the upstream bridge; others are downstream
// Notes: Link state requests go to the link layer, which reports back
`timescale 1ns/1ps
`default_nettype none
module fps_power_ctrl
	import fps_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Power state field writes
	input wire logic i_ps_wr,
	input wire logic [FN_W-1:0] i_ps_fn,
	input wire logic [1:0] i_ps_wdata,
	input wire logic [NUM_FN-1:0] i_fn_configured,
	// Fence protocol
	input wire logic i_pme_to_ack_done,
	// Link layer status per port
	input wire logic [NUM_FN-1:0] i_link_in_l0,
	input wire logic [NUM_FN-1:0] i_l1_req,
	input wire logic [NUM_FN-1:0] i_l1_req_aspm,
	input wire logic [NUM_FN-1:0] i_partner_d3,
	input wire logic [NUM_FN-1:0] i_aspm_l1_allow,
	// Received TLP to classify
	input wire logic i_tlp_vld,
	input wire logic [FN_W-1:0] i_tlp_fn,
	input wire logic i_tlp_secondary,
	input wire logic [1:0] i_tlp_kind,
	input wire logic i_tlp_to_bridge,
	input wire logic [FN_W-1:0] i_tlp_egress,
	// Error events
	input wire logic i_err_vld,
	input wire logic [FN_W-1:0] i_err_fn,
	input wire logic i_err_from_tlp,
	input wire logic i_err_rpt_en,
	// Outputs
	output logic [2*NUM_FN-1:0] o_fn_state,
	output logic [NUM_FN-1:0] o_context_kept_flag,
	output logic [NUM_FN-1:0] o_link_l0_req,
	output logic [NUM_FN-1:0] o_link_l1_req,
	output logic [NUM_FN-1:0] o_l1_accept,
	output logic [NUM_FN-1:0] o_l1_reject,
	output logic o_switch_low_power,
	output logic o_tlp_disp_vld,
	output logic [1:0] o_tlp_disp,
	output logic o_err_send,
	output logic o_err_drop
);
	fps_state_t fn_state [NUM_FN];
	logic [NUM_FN-1:0] fn_d3;
	logic [NUM_FN-1:0] fn_d0;
	logic [NUM_FN-1:0] wake_ff;
	logic [NUM_FN-1:0] nxt_wake;
	logic [2*NUM_FN-1:0] fn_state_ff;
	logic [NUM_FN-1:0] ctx_ff;
	logic [NUM_FN-1:0] l0_req_ff;
	logic [NUM_FN-1:0] l1_req_ff;
	logic [NUM_FN-1:0] l1_acc_ff;
	logic [NUM_FN-1:0] l1_rej_ff;
	logic low_power_ff;
	logic disp_vld_ff;
	logic [1:0] disp_ff;
	logic err_send_ff;
	logic err_drop_ff;
	logic [1:0] nxt_disp;
	logic fn_tlp_d3;
	logic err_d3;

	function automatic logic [NUM_FN-1:0] fn_onehot(
		input logic [FN_W-1:0] idx);
		logic [NUM_FN-1:0] res;
		res = '0;
		res[idx] = 1'b1;
		return res;
	endfunction : fn_onehot

	generate
		for (genvar g = 0; g < NUM_FN; g++) begin : g_fn
			fps_fn_state u_fn (
				.i_clk(i_clk),
				.i_rst_b(i_rst_b),
				.i_ps_wr(i_ps_wr && i_ps_fn == FN_W'(g)),
				.i_ps_wdata(i_ps_wdata),
				.i_configured(i_fn_configured[g]),
				.o_state(fn_state[g])
			);
			assign fn_d3[g] = fn_state[g] == FPS_D3H;
			assign fn_d0[g] = !fn_d3[g];
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fn_state_ff <= '0;
		end else begin
			for (int i = 0; i < NUM_FN; i++) begin
				fn_state_ff[2*i +: 2] <= fn_state[i];
			end
		end
	end

	// Flag is constant: no D3hot exit ever clears context
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctx_ff <= {NUM_FN{CTX_KEPT_RST}};
		end else begin
			ctx_ff <= {NUM_FN{CTX_KEPT_RST}};
		end
	end

	// Pending wake set by errors or completions, held until link in L0
	always_comb begin
		nxt_wake = wake_ff & ~i_link_in_l0;
		if (i_err_vld && i_err_from_tlp && i_err_rpt_en
			&& !i_link_in_l0[0]) begin
			nxt_wake[0] = 1'b1;
		end
		if (i_tlp_vld && i_tlp_kind == TLP_CPL && !i_tlp_to_bridge
			&& !i_link_in_l0[i_tlp_egress]) begin
			nxt_wake = nxt_wake | fn_onehot(i_tlp_egress);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wake_ff <= '0;
		end else begin
			wake_ff <= nxt_wake;
		end
	end

	// Link targets: L0 for D0 or pending wake, L1 once D3hot; upstream L1 only once all are D3hot
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			l0_req_ff <= '0;
			l1_req_ff <= '0;
		end else begin
			l0_req_ff <= fn_d0 | nxt_wake;
			l1_req_ff[0] <= (&fn_d3) && !nxt_wake[0];
			for (int i = 1; i < NUM_FN; i++) begin
				l1_req_ff[i] <= fn_d3[i] && !nxt_wake[i];
			end
		end
	end

	// Downstream answers to partner L1 requests
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			l1_acc_ff <= '0;
			l1_rej_ff <= '0;
		end else begin
			l1_acc_ff <= '0;
			l1_rej_ff <= '0;
			for (int i = 1; i < NUM_FN; i++) begin
				if (i_l1_req[i] && !i_l1_req_aspm[i] && i_partner_d3[i]) begin
					l1_acc_ff[i] <= 1'b1;
				end else if (i_l1_req[i] && i_l1_req_aspm[i]) begin
					l1_acc_ff[i] <= i_aspm_l1_allow[i];
					l1_rej_ff[i] <= !i_aspm_l1_allow[i];
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			low_power_ff <= 1'b0;
		end else begin
			low_power_ff <= fn_d3[0] && i_pme_to_ack_done;
		end
	end

	// TLP disposition; D0 behaviour is accept or forward
	assign fn_tlp_d3 = fn_d3[i_tlp_fn];

	always_comb begin
		nxt_disp = DISP_ACCEPT;
		if (i_tlp_kind == TLP_CPL) begin
			if (!i_tlp_to_bridge) begin
				nxt_disp = DISP_FWD;
			end else if (fn_tlp_d3) begin
				nxt_disp = DISP_UC;
			end
		end else if (i_tlp_kind == TLP_REQ && !i_tlp_to_bridge) begin
			nxt_disp = DISP_FWD;
		end
		if (fn_tlp_d3 && i_tlp_kind != TLP_CPL) begin
			if (i_tlp_secondary) begin
				nxt_disp = DISP_UR;
			end else if (i_tlp_kind == TLP_CFG0) begin
				nxt_disp = DISP_ACCEPT;
			end else if (i_tlp_kind == TLP_MSG && i_tlp_to_bridge) begin
				nxt_disp = DISP_ACCEPT;
			end else begin
				nxt_disp = DISP_UR;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			disp_vld_ff <= 1'b0;
			disp_ff <= DISP_ACCEPT;
		end else begin
			disp_vld_ff <= i_tlp_vld;
			disp_ff <= nxt_disp;
		end
	end

	// Error reporting; drop only non-TLP causes while in D3hot
	assign err_d3 = fn_d3[i_err_fn];

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			err_send_ff <= 1'b0;
			err_drop_ff <= 1'b0;
		end else begin
			err_send_ff <= i_err_vld && i_err_rpt_en
				&& (i_err_from_tlp || !err_d3);
			err_drop_ff <= i_err_vld && !i_err_from_tlp && err_d3;
		end
	end

	assign o_fn_state = fn_state_ff;
	assign o_context_kept_flag = ctx_ff;
	assign o_link_l0_req = l0_req_ff;
	assign o_link_l1_req = l1_req_ff;
	assign o_l1_accept = l1_acc_ff;
	assign o_l1_reject = l1_rej_ff;
	assign o_switch_low_power = low_power_ff;
	assign o_tlp_disp_vld = disp_vld_ff;
	assign o_tlp_disp = disp_ff;
	assign o_err_send = err_send_ff;
	assign o_err_drop = err_drop_ff;

	AST_ISOLATE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_ps_wr && i_ps_fn != FN_W'(1) && !i_fn_configured[1])
		|=> $stable(fn_state[1]))
		else $error("Function 1 changed on another Function's write");
	AST_LOW_PWR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_switch_low_power |-> $past(fn_d3[0] && i_pme_to_ack_done))
		else $error("Low power without upstream D3hot and ack");
	AST_UP_L1: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_link_l1_req[0] |-> $past(&fn_d3))
		else $error("Upstream L1 before all Functions in D3hot");
	AST_D0_L0: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		fn_d0[2] |=> o_link_l0_req[2])
		else $error("D0 Function link not requested in L0");
	AST_DS_ACCEPT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_l1_req[1] && !i_l1_req_aspm[1] && i_partner_d3[1])
		|=> o_l1_accept[1] && !o_l1_reject[1])
		else $error("Partner D3hot L1 request not accepted");
	AST_SEC_UR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_tlp_vld && i_tlp_secondary && fn_tlp_d3 && i_tlp_kind != TLP_CPL)
		|=> o_tlp_disp_vld && o_tlp_disp == DISP_UR)
		else $error("Secondary request in D3hot not UR");
	AST_CFG0: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_tlp_vld && !i_tlp_secondary && fn_tlp_d3 && i_tlp_kind == TLP_CFG0)
		|=> o_tlp_disp == DISP_ACCEPT)
		else $error("Type 0 config in D3hot not accepted");
	AST_CPL_UC: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_tlp_vld && fn_tlp_d3 && i_tlp_kind == TLP_CPL && i_tlp_to_bridge)
		|=> o_tlp_disp == DISP_UC)
		else $error("Completion to D3hot bridge not UC");
	AST_ERR_DROP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_err_vld && !i_err_from_tlp && err_d3) |=> o_err_drop && !o_err_send)
		else $error("Non-TLP error in D3hot not dropped");
	AST_WAKE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_err_vld && i_err_from_tlp && i_err_rpt_en && !i_link_in_l0[0])
		|=> o_link_l0_req[0] && !o_link_l1_req[0])
		else $error("Error send did not wake upstream link");

	// Link targets per Function state, switch low power and ASPM L1 rejection
	AST_D3_L1: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(fn_d3[1] && !nxt_wake[1])
		|=> o_link_l1_req[1] && !o_link_l0_req[1])
		else $error("D3hot Function link not moved to L1");
	AST_D0_NO_L1: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		fn_d0[3] |=> o_link_l0_req[3] && !o_link_l1_req[3])
		else $error("D0 Function link asked for L1");
	AST_LOW_SET: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(fn_d3[0] && i_pme_to_ack_done) |=> o_switch_low_power)
		else $error("Low power not entered after upstream D3hot and ack");
	AST_ASPM_REJ: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_l1_req[3] && i_l1_req_aspm[3] && !i_aspm_l1_allow[3])
		|=> o_l1_reject[3] && !o_l1_accept[3])
		else $error("Disallowed ASPM L1 request not rejected");

	// Request policy while in D3hot, completions in passing
	AST_MSG_BR: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_tlp_vld && !i_tlp_secondary && fn_tlp_d3 && i_tlp_kind == TLP_MSG
		&& i_tlp_to_bridge) |=> o_tlp_disp == DISP_ACCEPT)
		else $error("Message to D3hot bridge not accepted");
	AST_PRI_UR: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_tlp_vld && !i_tlp_secondary && fn_tlp_d3 && (i_tlp_kind == TLP_REQ
		|| (i_tlp_kind == TLP_MSG && !i_tlp_to_bridge)))
		|=> o_tlp_disp_vld && o_tlp_disp == DISP_UR)
		else $error("Primary request in D3hot not UR");
	AST_CPL_FWD: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_tlp_vld && i_tlp_kind == TLP_CPL && !i_tlp_to_bridge)
		|=> o_tlp_disp_vld && o_tlp_disp == DISP_FWD)
		else $error("Passing completion not forwarded");

	// Error reporting and pending wakes
	AST_ERR_SEND: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_err_vld && i_err_from_tlp && i_err_rpt_en)
		|=> o_err_send && !o_err_drop)
		else $error("TLP-caused error not reported");
	AST_CPL_WAKE: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_tlp_vld && i_tlp_kind == TLP_CPL && !i_tlp_to_bridge
		&& i_tlp_egress == FN_W'(1) && !i_link_in_l0[1])
		|=> o_link_l0_req[1] && !o_link_l1_req[1])
		else $error("Completion did not wake its egress link");
	AST_HOLD_ERR: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(wake_ff[0] && !i_link_in_l0[0]) |=> o_link_l0_req[0])
		else $error("Error wake dropped before link reached L0");
	AST_HOLD_CPL: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(wake_ff[1] && !i_link_in_l0[1]) |=> o_link_l0_req[1])
		else $error("Completion wake dropped before link reached L0");
endmodule : fps_power_ctrl
`default_nettype wire

/* File: tb/fps_link_model.sv */
// Purpose: Link layer stand-in for every switch port
// Assumes: Link requests from the block are levels
// Notes: L0 training takes LAT+1 cycles so slow links are exercised
`timescale 1ns/1ps
`default_nettype none
module fps_link_model
	import fps_pkg::*;
#(
	parameter int LAT = 4
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Requests from the block
	input wire logic [NUM_FN-1:0] i_l0_req,
	input wire logic [NUM_FN-1:0] i_l1_req,
	// Link status
	output logic [NUM_FN-1:0] o_in_l0
);
	int cnt_ff [NUM_FN];

	// Links come up untrained; L0 only after the block asks for it
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_in_l0 <= '0;
			for (int p = 0; p < NUM_FN; p++) cnt_ff[p] <= 0;
		end else begin
			for (int p = 0; p < NUM_FN; p++) begin
				if (i_l0_req[p] && !o_in_l0[p]) begin
					cnt_ff[p] <= cnt_ff[p] + 1;
					if (cnt_ff[p] == LAT) o_in_l0[p] <= 1'b1;
				end else if (i_l1_req[p] && !i_l0_req[p]) begin
					o_in_l0[p] <= 1'b0;
					cnt_ff[p] <= 0;
				end else begin
					cnt_ff[p] <= 0;
				end
			end
		end
	end
endmodule : fps_link_model
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the Function power state block
// Assumes: Function 0 is upstream; inputs driven at falling edge
// Notes: Link status comes from the link model, never from the bench
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fps_pkg::*;
	logic i_clk = 0, i_rst_b = 0, i_ps_wr = 0, i_pme_to_ack_done = 0;
	logic [1:0] i_ps_fn = 0, i_ps_wdata = 0, i_tlp_fn = 0, i_tlp_kind = 0;
	logic [1:0] i_tlp_egress = 0, i_err_fn = 0, o_tlp_disp;
	logic [3:0] i_fn_configured = 0, i_l1_req = 0, i_l1_req_aspm = 0;
	logic [3:0] i_partner_d3 = 0, i_aspm_l1_allow = 0, link_l0;
	logic [3:0] o_ctx, o_l0_req, o_l1_req, o_l1_acc, o_l1_rej;
	logic i_tlp_vld = 0, i_tlp_secondary = 0, i_tlp_to_bridge = 0;
	logic i_err_vld = 0, i_err_from_tlp = 0, i_err_rpt_en = 1;
	logic o_low, o_disp_vld, o_err_send, o_err_drop;
	logic [7:0] o_fn_state;
	int num_errors = 0, n_tests = 0;

	always #5 i_clk = ~i_clk;

	fps_power_ctrl dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_ps_wr(i_ps_wr), .i_ps_fn(i_ps_fn), .i_ps_wdata(i_ps_wdata),
		.i_fn_configured(i_fn_configured),
		.i_pme_to_ack_done(i_pme_to_ack_done), .i_link_in_l0(link_l0),
		.i_l1_req(i_l1_req), .i_l1_req_aspm(i_l1_req_aspm),
		.i_partner_d3(i_partner_d3), .i_aspm_l1_allow(i_aspm_l1_allow),
		.i_tlp_vld(i_tlp_vld), .i_tlp_fn(i_tlp_fn),
		.i_tlp_secondary(i_tlp_secondary), .i_tlp_kind(i_tlp_kind),
		.i_tlp_to_bridge(i_tlp_to_bridge), .i_tlp_egress(i_tlp_egress),
		.i_err_vld(i_err_vld), .i_err_fn(i_err_fn),
		.i_err_from_tlp(i_err_from_tlp), .i_err_rpt_en(i_err_rpt_en),
		.o_fn_state(o_fn_state), .o_context_kept_flag(o_ctx),
		.o_link_l0_req(o_l0_req), .o_link_l1_req(o_l1_req),
		.o_l1_accept(o_l1_acc), .o_l1_reject(o_l1_rej),
		.o_switch_low_power(o_low), .o_tlp_disp_vld(o_disp_vld),
		.o_tlp_disp(o_tlp_disp), .o_err_send(o_err_send),
		.o_err_drop(o_err_drop));

	fps_link_model #(.LAT(4)) link_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_l0_req(o_l0_req), .i_l1_req(o_l1_req), .o_in_l0(link_l0));

	task automatic give_verdict();
		$display("Checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [7:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s expected %0h seen %0h", what, exp, got);
			num_errors++;
		end
	endtask : chk

	task automatic ps_write(input logic [1:0] fn, data);
		@(negedge i_clk);
		i_ps_wr = 1;
		i_ps_fn = fn;
		i_ps_wdata = data;
		@(negedge i_clk);
		i_ps_wr = 0;
		repeat (3) @(negedge i_clk);
	endtask : ps_write

	// Pulse is caught at either of the two following falling edges
	task automatic tlp(input logic [1:0] fn, input logic sec,
		input logic [1:0] kind, input logic tobr, input logic [1:0] egr,
		input logic [1:0] exp);
		logic seen;
		logic [1:0] d;
		seen = 0;
		d = 0;
		@(negedge i_clk);
		{i_tlp_vld, i_tlp_fn, i_tlp_secondary} = {1'b1, fn, sec};
		{i_tlp_kind, i_tlp_to_bridge, i_tlp_egress} = {kind, tobr, egr};
		@(negedge i_clk);
		i_tlp_vld = 0;
		repeat (2) begin
			if (o_disp_vld === 1'b1 && !seen) begin
				seen = 1;
				d = o_tlp_disp;
			end
			@(negedge i_clk);
		end
		chk("disp valid", 8'h01, {7'h0, seen});
		chk("disposition", {6'h0, exp}, {6'h0, d});
	endtask : tlp

	task automatic err(input logic [1:0] fn, input logic from_tlp);
		logic [1:0] sd;
		sd = 0;
		@(negedge i_clk);
		{i_err_vld, i_err_fn, i_err_from_tlp} = {1'b1, fn, from_tlp};
		@(negedge i_clk);
		i_err_vld = 0;
		repeat (2) begin
			sd = sd | {o_err_send, o_err_drop};
			@(negedge i_clk);
		end
		chk("error send drop", from_tlp ? 8'h02 : 8'h01, {6'h0, sd});
	endtask : err

	task automatic l1(input int p, input logic aspm, pd3, allow, acc);
		@(negedge i_clk);
		i_l1_req[p] = 1;
		i_l1_req_aspm[p] = aspm;
		i_partner_d3[p] = pd3;
		i_aspm_l1_allow[p] = allow;
		repeat (2) @(negedge i_clk);
		chk("l1 answer", acc ? 8'h02 : 8'h01, {6'h0, o_l1_acc[p], o_l1_rej[p]});
		i_l1_req[p] = 0;
		repeat (2) @(negedge i_clk);
	endtask : l1

	// Bounded wait for the link model to settle
	task automatic wait_link(input int p, input logic v);
		for (int k = 0; k < 20 && link_l0[p] !== v; k++) @(negedge i_clk);
		chk("link state", {7'h0, v}, {7'h0, link_l0[p]});
	endtask : wait_link

	task automatic t_reset_config();
		repeat (3) @(negedge i_clk);
		chk("state after reset", 8'h00, o_fn_state);
		chk("context flag", 8'h0F, {4'h0, o_ctx});
		chk("l0 request", 8'h0F, {4'h0, o_l0_req});
		ps_write(2'h3, PS_D3_ENC);
		chk("d3 from d0u ignored", 8'h00, o_fn_state);
		i_fn_configured = 4'hF;
		repeat (3) @(negedge i_clk);
		chk("configured", 8'h55, o_fn_state);
	endtask : t_reset_config

	task automatic t_d3_policy();
		ps_write(2'h1, PS_D3_ENC);
		chk("fn1 d3 others kept", 8'h59, o_fn_state);
		chk("l1 request", 8'h02, {4'h0, o_l1_req});
		ps_write(2'h1, 2'h1);
		chk("d1 code ignored", 8'h59, o_fn_state);
		tlp(2'h1, 0, TLP_CFG0, 0, 2'h0, DISP_ACCEPT);
		tlp(2'h1, 0, TLP_MSG, 1, 2'h0, DISP_ACCEPT);
		tlp(2'h1, 0, TLP_REQ, 0, 2'h0, DISP_UR);
		tlp(2'h1, 0, TLP_MSG, 0, 2'h0, DISP_UR);
		tlp(2'h1, 1, TLP_REQ, 0, 2'h0, DISP_UR);
		tlp(2'h1, 1, TLP_CPL, 1, 2'h0, DISP_UC);
		tlp(2'h1, 0, TLP_CPL, 0, 2'h2, DISP_FWD);
		tlp(2'h2, 0, TLP_REQ, 0, 2'h0, DISP_FWD);
		err(2'h1, 1);
		err(2'h1, 0);
		wait_link(1, 0);
		tlp(2'h2, 0, TLP_CPL, 0, 2'h1, DISP_FWD);
		chk("wake for completion", 8'h01, {7'h0, o_l0_req[1]});
		wait_link(1, 1);
	endtask : t_d3_policy

	task automatic t_l1_answers();
		l1(2, 0, 1, 0, 1);
		l1(1, 0, 1, 0, 1);
		l1(3, 1, 0, 0, 0);
		l1(3, 1, 0, 1, 1);
	endtask : t_l1_answers

	task automatic t_wake_d0();
		i_fn_configured[1] = 0;
		ps_write(2'h1, PS_D0_ENC);
		chk("d3 to d0u", 8'h51, o_fn_state);
		chk("context kept", 8'h0F, {4'h0, o_ctx});
		chk("l0 on d0", 8'h01, {7'h0, o_l0_req[1]});
		i_fn_configured[1] = 1;
		repeat (3) @(negedge i_clk);
	endtask : t_wake_d0

	task automatic t_low_power();
		i_pme_to_ack_done = 1;
		for (int f = 1; f < NUM_FN; f++) ps_write(f[1:0], PS_D3_ENC);
		chk("upstream l1 early", 8'h00, {7'h0, o_l1_req[0]});
		chk("low power early", 8'h00, {7'h0, o_low});
		ps_write(2'h0, PS_D3_ENC);
		chk("all d3", 8'hAA, o_fn_state);
		chk("upstream l1", 8'h01, {7'h0, o_l1_req[0]});
		chk("low power", 8'h01, {7'h0, o_low});
		wait_link(0, 0);
		err(2'h0, 1);
		chk("wake for error", 8'h01, {7'h0, o_l0_req[0]});
	endtask : t_low_power

	// Reset in mid-run must drop every Function back to D0 uninitialized
	task automatic t_mid_reset();
		i_fn_configured = 4'h0;
		i_rst_b = 0;
		repeat (2) @(negedge i_clk);
		chk("state in reset", 8'h00, o_fn_state);
		chk("context in reset", 8'h0F, {4'h0, o_ctx});
		i_rst_b = 1;
		repeat (3) @(negedge i_clk);
		chk("d3 to d0u by reset", 8'h00, o_fn_state);
		chk("l0 after reset", 8'h0F, {4'h0, o_l0_req});
		chk("low power after reset", 8'h00, {7'h0, o_low});
	endtask : t_mid_reset

	initial begin
		repeat (12) @(negedge i_clk);
		i_rst_b = 1;
		t_reset_config();
		t_d3_policy();
		t_l1_answers();
		t_wake_d0();
		t_low_power();
		t_mid_reset();
		give_verdict();
	end

	// Whole sequence needs well under a thousand cycles
	initial begin
		#30000;
		num_errors++;
		give_verdict();
	end
endmodule : tb
`default_nettype wire
